//--- design/ccc_pkg.sv
// Purpose : Constants for the calibration correction chain
// Assumes : 24-bit two's complement coefficients, byte-wide control
// Notes   : Gain codes carry 22 fraction bits, so 0x40_0000 is unity
package ccc_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int COEF_W  = 24;   // Coefficient and result width
    localparam int CTRL_W  = 8;    // Control register width
    localparam int WORK_W  = 32;   // Internal working width
    localparam int PROD_W  = 56;   // Product width, working x coef
    localparam int FRAC_W  = 22;   // Gain fraction bits
    localparam int LIM_W   = 26;   // Intermediate clamp width
    localparam int SEL_W   = 3;    // Register select width
    localparam int STAGES  = 5;    // Pipeline depth

    // ****************************************************************
    // Register select codes on the access port
    // ****************************************************************
    localparam logic [2:0] SEL_SELF_OFS = 3'h0;
    localparam logic [2:0] SEL_SELF_GN  = 3'h1;
    localparam logic [2:0] SEL_SYS_OFS  = 3'h2;
    localparam logic [2:0] SEL_SYS_GN   = 3'h3;
    localparam logic [2:0] SEL_CTRL     = 3'h4;

    // ****************************************************************
    // Control register field positions
    // ****************************************************************
    localparam int DGAIN_HI      = 7;  // digital_gain_select [7:5]
    localparam int DGAIN_LO      = 5;
    localparam int BIT_SYS_GN    = 4;  // sys_gain_bypass
    localparam int BIT_SYS_OFS   = 3;  // sys_offset_bypass
    localparam int BIT_SELF_GN   = 2;  // self_gain_bypass
    localparam int BIT_SELF_OFS  = 1;  // self_offset_bypass
    localparam logic [7:0] CTRL_WMASK = 8'hFE;  // Bit 0 reserved

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  CTRL_RESET = 8'h1E;
    localparam logic [23:0] COEF_RESET = 24'h00_0000;
    localparam logic [2:0]  DGAIN_MAX  = 3'h4;  // Shift of 4, gain 16

    // ****************************************************************
    // Output clamp codes
    // ****************************************************************
    localparam logic [23:0] OUT_MAX = 24'h7F_FFFF;
    localparam logic [23:0] OUT_MIN = 24'h80_0000;
endpackage

//--- design/ccc_calibration_correction_chain.sv
// Purpose : Applies offset and gain calibration to each raw result
// Assumes : Serial framing logic sits outside on the same clock
// Notes   : Five-cycle fixed latency, one result per clock possible
//
// Function
// - 24-bit system gain register, shifted MSB first
// - All coefficients are two's complement values
// - System gain kept until rewritten or calibrated
// - Bypass bit 0 applies system gain multiply
// - System gain scales up to two times
// - Gain stages accurate within two LSB
// - 24-bit self offset register, MSB first
// - Self coefficients kept until rewritten or calibrated
// - Bypass bit 0 subtracts self offset
// - Self offset subtraction comes first
// - Self offset precedes unipolar doubling
// - 24-bit self gain register, MSB first
// - Self gain writes dropped during calibration
// - Self gain scales before system corrections
// - Self gain scales up to two times
// - Bypass bits: 1 disables, reset to 1
// - System offset between self and system gain
// - Digital gain applied after all calibration
// - Out of range results clamp to limits
`timescale 1ns/1ns
`default_nettype none
module ccc_calibration_correction_chain (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    // Register access port from the serial framing logic
    input  wire logic [ccc_pkg::SEL_W-1:0]     acc_sel,
    input  wire logic                          acc_start,
    input  wire logic                          acc_shift,
    input  wire logic                          acc_sdi,
    input  wire logic                          acc_commit,
    output logic                               acc_sdo,
    // Calibration sequencer results
    input  wire logic                          cal_busy,
    input  wire logic                          cal_load,
    input  wire logic [ccc_pkg::SEL_W-1:0]     cal_sel,
    input  wire logic [ccc_pkg::COEF_W-1:0]    cal_value,
    // Raw conversion stream
    input  wire logic                          raw_valid,
    input  wire logic [ccc_pkg::COEF_W-1:0]    raw_data,
    input  wire logic                          unipolar_mode,
    // Corrected stream
    output logic                               result_valid,
    output logic [ccc_pkg::COEF_W-1:0]         result_data,
    output logic [ccc_pkg::CTRL_W-1:0]         control_state
);
    import ccc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [COEF_W-1:0]        self_offset_coefficient;
        logic [COEF_W-1:0]        self_gain_coefficient;
        logic [COEF_W-1:0]        sys_offset_coefficient;
        logic [COEF_W-1:0]        system_gain_coefficient;
        logic [CTRL_W-1:0]        calibration_control_register;
        logic [COEF_W-1:0]        shifter;      // Serial access shifter
        logic                     sdo;          // Registered serial out
        logic [STAGES-1:0]        valid_pipe;   // Stage valid flags
        logic signed [WORK_W-1:0] stage1;       // After self offset
        logic signed [WORK_W-1:0] stage2;       // After self gain
        logic signed [WORK_W-1:0] stage3;       // After sys offset
        logic signed [WORK_W-1:0] stage4;       // After sys gain
        logic [COEF_W-1:0]        result;       // Clamped output
    } ccc_state_type;

    ccc_state_type state;       // Registered state
    ccc_state_type next_state;  // Next value
    logic          rst_meta;    // Reset release synchroniser
    logic          rst_sync_n;  // Synchronised reset

    // ****************************************************************
    // Arithmetic helpers
    // ****************************************************************

    // Clamp a wide value into the intermediate range, so later
    // adds and shifts in the working width cannot wrap
    function automatic logic signed [WORK_W-1:0] ccc_limit(
        input logic signed [PROD_W-1:0] v
    );
        logic signed [WORK_W-1:0] r;
        r = v[WORK_W-1:0];
        if (v[PROD_W-1:LIM_W-1] != {(PROD_W-LIM_W+1){v[PROD_W-1]}}) begin
            // Saturate toward the sign
            r = v[PROD_W-1] ? -(32'sd1 <<< (LIM_W-1))
                            : (32'sd1 <<< (LIM_W-1)) - 32'sd1;
        end
        return r;
    endfunction

    // Gain multiply, code/2^22, so 0x7F_FFFF is just under two;
    // rounding to nearest keeps the error well inside two LSB
    function automatic logic signed [WORK_W-1:0] ccc_gain(
        input logic signed [WORK_W-1:0] x,
        input logic [COEF_W-1:0]        k
    );
        logic signed [PROD_W-1:0] p;
        p = x * $signed(k);
        p = p + (56'sd1 <<< (FRAC_W-1));
        p = p >>> FRAC_W;
        return ccc_limit(p);
    endfunction

    // Subtract a two's complement coefficient with sign extension
    function automatic logic signed [WORK_W-1:0] ccc_sub(
        input logic signed [WORK_W-1:0] x,
        input logic [COEF_W-1:0]        k
    );
        logic signed [PROD_W-1:0] d;
        d = PROD_W'(x) - PROD_W'($signed(k));
        return ccc_limit(d);
    endfunction

    // ****************************************************************
    // Reset release
    // ****************************************************************

    // Assert at once, release after two edges
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [COEF_W-1:0]        sel_value;
        logic [CTRL_W-1:0]        ctrl;
        logic signed [WORK_W-1:0] v;
        logic [2:0]               shift_amt;
        sel_value  = COEF_RESET;
        ctrl       = state.calibration_control_register;
        v          = '0;
        shift_amt  = 3'h0;
        next_state = state;

        // Register readback source, control sits in the top byte
        // so its MSB leaves first
        unique case (acc_sel)
            SEL_SELF_OFS: sel_value = state.self_offset_coefficient;
            SEL_SELF_GN:  sel_value = state.self_gain_coefficient;
            SEL_SYS_OFS:  sel_value = state.sys_offset_coefficient;
            SEL_SYS_GN:   sel_value = state.system_gain_coefficient;
            SEL_CTRL:     sel_value = {ctrl & CTRL_WMASK, 16'h0000};
            default:      sel_value = COEF_RESET;  // Unmapped reads 0
        endcase

        // Serial shifter, MSB first in and out
        if (acc_start) begin
            next_state.shifter = sel_value;
        end else if (acc_shift) begin
            next_state.shifter = {state.shifter[COEF_W-2:0], acc_sdi};
        end
        next_state.sdo = next_state.shifter[COEF_W-1];

        // Host write; values persist until the next write or load
        if (acc_commit) begin
            unique case (acc_sel)
                SEL_SELF_OFS:
                    next_state.self_offset_coefficient = state.shifter;
                SEL_SELF_GN: begin
                    // Ignored while a calibration runs
                    if (!cal_busy) begin
                        next_state.self_gain_coefficient =
                            state.shifter;
                    end
                end
                SEL_SYS_OFS:
                    next_state.sys_offset_coefficient = state.shifter;
                SEL_SYS_GN:
                    next_state.system_gain_coefficient =
                        state.shifter;
                SEL_CTRL:
                    next_state.calibration_control_register =
                        state.shifter[CTRL_W-1:0] & CTRL_WMASK;
                default: ;  // Unmapped writes dropped
            endcase
        end

        // Calibration results overwrite host values; applied last
        // so a measured value wins a same-cycle host write
        if (cal_load) begin
            unique case (cal_sel)
                SEL_SELF_OFS:
                    next_state.self_offset_coefficient = cal_value;
                SEL_SELF_GN:
                    next_state.self_gain_coefficient = cal_value;
                SEL_SYS_OFS:
                    next_state.sys_offset_coefficient = cal_value;
                SEL_SYS_GN:
                    next_state.system_gain_coefficient = cal_value;
                default: ;  // Control is never calibrated
            endcase
        end

        // Stage 1: self offset comes first of all
        v = $signed({{(WORK_W-COEF_W){raw_data[COEF_W-1]}}, raw_data});
        if (!ctrl[BIT_SELF_OFS]) begin
            v = ccc_sub(v, state.self_offset_coefficient);
        end
        next_state.stage1 = v;

        // Stage 2: self gain, before any system correction
        v = state.stage1;
        if (!ctrl[BIT_SELF_GN]) begin
            v = ccc_gain(v, state.self_gain_coefficient);
        end
        next_state.stage2 = v;

        // Stage 3: system offset, then unipolar doubling
        v = state.stage2;
        if (!ctrl[BIT_SYS_OFS]) begin
            v = ccc_sub(v, state.sys_offset_coefficient);
        end
        if (unipolar_mode) begin
            // Doubling after every offset
            v = v <<< 1;
        end
        next_state.stage3 = v;

        // Stage 4: system gain
        v = state.stage3;
        if (!ctrl[BIT_SYS_GN]) begin
            v = ccc_gain(v, state.system_gain_coefficient);
        end
        next_state.stage4 = v;

        // Stage 5: digital gain on the fully corrected value
        shift_amt = ctrl[DGAIN_HI:DGAIN_LO];
        if (shift_amt > DGAIN_MAX) begin
            // Undefined codes hold the top gain
            shift_amt = DGAIN_MAX;
        end
        v = state.stage4 <<< shift_amt;
        if (!state.valid_pipe[STAGES-2]) begin
            // No sample in stage 4, so the old result stands
            next_state.result = state.result;
        end else if (v[WORK_W-1:COEF_W-1] !=
                     {(WORK_W-COEF_W+1){v[WORK_W-1]}}) begin
            // Out of range, pin to the end code
            next_state.result = v[WORK_W-1] ? OUT_MIN : OUT_MAX;
        end else begin
            next_state.result = v[COEF_W-1:0];
        end

        // Valid flags travel with the data
        next_state.valid_pipe = {state.valid_pipe[STAGES-2:0], raw_valid};
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // All coefficients clear, all bypass bits set at reset
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state                              <= '0;
            state.calibration_control_register <= CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs, straight from flip-flops
    // ****************************************************************
    assign acc_sdo       = state.sdo;
    assign result_valid  = state.valid_pipe[STAGES-1];
    assign result_data   = state.result;
    assign control_state = state.calibration_control_register;
endmodule
`default_nettype wire

//--- test/ccc_chain_checker.sv
// Purpose : Port-level timing checks for the correction chain
// Assumes : One clock, rst_n asynchronous and active low
// Notes   : Bound to the design from the bench top file
`timescale 1ns/1ns
`default_nettype none
module ccc_chain_checker (
    // Clock and reset
    input wire logic                       clock,
    input wire logic                       rst_n,
    // Access port
    input wire logic [ccc_pkg::SEL_W-1:0]  acc_sel,
    input wire logic                       acc_start,
    input wire logic                       acc_shift,
    input wire logic                       acc_commit,
    input wire logic                       acc_sdo,
    // Streams
    input wire logic                       raw_valid,
    input wire logic [ccc_pkg::COEF_W-1:0] raw_data,
    input wire logic                       unipolar_mode,
    input wire logic                       result_valid,
    input wire logic [ccc_pkg::COEF_W-1:0] result_data,
    input wire logic [ccc_pkg::CTRL_W-1:0] control_state
);
    import ccc_pkg::*;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    lat_a: assert property (raw_valid |-> ##5 result_valid)
        else $error("result missing five cycles after sample");
    spur_a: assert property (result_valid |-> $past(raw_valid, 5))
        else $error("result without a sample");
    // Full bypass must pass the raw code through untouched
    bypass_a: assert property (raw_valid && control_state == CTRL_RESET
        && !unipolar_mode ##1 (control_state == CTRL_RESET
        && !unipolar_mode)[*5] |-> result_data == $past(raw_data, 5))
        else $error("bypassed result differs from raw");
    hold_a: assert property ($changed(result_data) |-> result_valid)
        else $error("result changed without valid");
    bit0_a: assert property (control_state[0] == 1'b0)
        else $error("reserved control bit set");
    ctrl_keep_a: assert property (!(acc_commit && acc_sel == SEL_CTRL)
        |=> $stable(control_state))
        else $error("control changed without a write");
    sdo_msb_a: assert property (acc_start && acc_sel == SEL_CTRL
        |=> {acc_sdo, 7'h00} == ($past(control_state) & 8'h80))
        else $error("first bit out is not the MSB");
    sdo_unmap_a: assert property (acc_start && acc_sel > SEL_CTRL
        |=> !acc_sdo) else $error("unmapped read not zero");
    sdo_keep_a: assert property (!acc_start && !acc_shift
        |=> $stable(acc_sdo)) else $error("serial out moved while idle");
endmodule
`default_nettype wire

//--- test/ccc_host_model.sv
// Purpose : Serial host that shifts register words in and out
// Assumes : Drives every access signal at the falling edge
// Notes   : One task does read and optional write in one frame
`timescale 1ns/1ns
`default_nettype none
module ccc_host_model (
    // Clock
    input  wire logic                       clock,
    // Access port
    output var  logic [ccc_pkg::SEL_W-1:0]  acc_sel,
    output var  logic                       acc_start,
    output var  logic                       acc_shift,
    output var  logic                       acc_sdi,
    output var  logic                       acc_commit,
    input  wire logic                       acc_sdo
);
    import ccc_pkg::*;
    // ****************************************************************
    // Frame task
    // ****************************************************************
    initial begin
        acc_sel = SEL_SELF_OFS;
        acc_start = 1'b0;
        acc_shift = 1'b0;
        acc_sdi = 1'b0;
        acc_commit = 1'b0;
    end
    // Start, n shifts MSB first, then optional commit
    task automatic xfer(input logic [SEL_W-1:0] sel, input int n,
        input logic [COEF_W-1:0] w, input logic cm,
        output logic [COEF_W-1:0] r);
        r = COEF_RESET;
        @(negedge clock);
        acc_sel = sel;
        acc_start = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clock);
            acc_start = 1'b0;
            r[i] = acc_sdo;
            acc_shift = 1'b1;
            acc_sdi = w[i];
        end
        @(negedge clock);
        acc_shift = 1'b0;
        // Idle data line flips so a stale bit is never reused
        acc_sdi = ~acc_sdi;
        acc_commit = cm;
        @(negedge clock);
        acc_commit = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/ccc_calibration_correction_chain_tb_top.sv
// Purpose : Register and datapath tests for the correction chain
// Assumes : Inputs change at the falling edge only
// Notes   : Coefficients chosen so intermediates never saturate
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    error_cnt++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ccc_calibration_correction_chain_tb_top;
    import ccc_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic [SEL_W-1:0]  acc_sel, cal_sel;
    logic              acc_start, acc_shift, acc_sdi, acc_commit, acc_sdo;
    logic              cal_busy, cal_load, raw_valid, unipolar_mode;
    logic [COEF_W-1:0] cal_value, raw_data, result_data, rd, ex;
    logic              result_valid;
    logic [CTRL_W-1:0] control_state, ctrl;
    logic [COEF_W-1:0] coef [4] = '{24'h00_1000, 24'h60_0000,
                                    24'hFF_F800, 24'h12_3456};
    logic [COEF_W-1:0] yg = 24'h30_0000;
    logic [CTRL_W-1:0] cfgs [10] = '{8'h1E, 8'h1C, 8'h1A, 8'h16, 8'h0E,
                                     8'h00, 8'h00, 8'h80, 8'hE0, 8'h18};
    logic [COEF_W-1:0] raws [3] = '{24'h12_3457, 24'hF0_0001, 24'h7F_FFFF};
    logic [COEF_W-1:0] exq [$];
    int                error_cnt = 0, n_compared = 0, cyc = 0;
    logic              uni;

    always #10 clock = ~clock;
    ccc_calibration_correction_chain DUT (.clock, .rst_n, .acc_sel,
        .acc_start, .acc_shift, .acc_sdi, .acc_commit, .acc_sdo, .cal_busy,
        .cal_load, .cal_sel, .cal_value, .raw_valid, .raw_data,
        .unipolar_mode, .result_valid, .result_data, .control_state);
    ccc_host_model u_host (.clock, .acc_sel, .acc_start, .acc_shift,
        .acc_sdi, .acc_commit, .acc_sdo);

    // ****************************************************************
    // Reference arithmetic
    // ****************************************************************
    function automatic logic signed [63:0] sx(input logic [23:0] x);
        return {{40{x[23]}}, x};
    endfunction
    function automatic logic [COEF_W-1:0] model(input logic [23:0] x);
        logic signed [63:0] v;
        v = sx(x);
        if (!ctrl[BIT_SELF_OFS]) v = v - sx(coef[0]);
        if (!ctrl[BIT_SELF_GN]) v = (v * sx(coef[1]) + 64'sh20_0000) >>> 22;
        if (!ctrl[BIT_SYS_OFS]) v = v - sx(coef[2]);
        if (uni) v = v * 2;
        if (!ctrl[BIT_SYS_GN]) v = (v * sx(yg) + 64'sh20_0000) >>> 22;
        v = v <<< ((ctrl[7:5] > DGAIN_MAX) ? DGAIN_MAX : ctrl[7:5]);
        if (v > 64'sh7F_FFFF) v = 64'sh7F_FFFF;
        if (v < -64'sh80_0000) v = -64'sh80_0000;
        return v[23:0];
    endfunction

    // Results checked at the falling edge, once settled
    always @(negedge clock) begin
        if (result_valid === 1'b1) begin
            ex = (exq.size() > 0) ? exq.pop_front() : 24'hXX_XXXX;
            `CHK(result_data, ex)
        end
    end
    // Hang guard, far above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic pulse_load(input logic [2:0] s, input logic [23:0] v);
        @(negedge clock);
        cal_load = 1'b1;
        cal_sel = s;
        cal_value = v;
        @(negedge clock);
        cal_load = 1'b0;
        cal_value = ~v;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {cal_busy, cal_load, raw_valid, unipolar_mode} = 4'h0;
        cal_sel = SEL_SELF_OFS;
        {cal_value, raw_data} = 48'h0;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        `CHK(control_state, CTRL_RESET)
        for (int s = 0; s < 6; s++) begin
            u_host.xfer(3'(s), (s == 4) ? 8 : 24, 24'h00_0000, 1'b0, rd);
            `CHK(rd, (s == 4) ? 24'(CTRL_RESET) : COEF_RESET)
        end
        // Host writes persist and read back MSB first
        for (int s = 0; s < 4; s++) begin
            u_host.xfer(3'(s), 24, coef[s], 1'b1, rd);
            u_host.xfer(3'(s), 24, 24'h00_0000, 1'b0, rd);
            `CHK(rd, coef[s])
        end
        u_host.xfer(3'h5, 24, 24'hFF_FFFF, 1'b1, rd);
        u_host.xfer(3'h5, 24, 24'h00_0000, 1'b0, rd);
        `CHK(rd, COEF_RESET)
        // Calibration overwrites a host value; select 4 is ignored
        pulse_load(SEL_SYS_GN, yg);
        pulse_load(SEL_CTRL, 24'hFF_FFFF);
        u_host.xfer(SEL_SYS_GN, 24, 24'h00_0000, 1'b0, rd);
        `CHK(rd, yg)
        `CHK(control_state, CTRL_RESET)
        // Measured self and offset values replace host values too
        for (int s = 0; s < 3; s++) begin
            coef[s] = coef[s] ^ 24'h00_0100;
            pulse_load(3'(s), coef[s]);
            u_host.xfer(3'(s), 24, 24'h00_0000, 1'b0, rd);
            `CHK(rd, coef[s])
        end
        cal_busy = 1'b1;
        u_host.xfer(SEL_SELF_GN, 24, 24'h00_0001, 1'b1, rd);
        cal_busy = 1'b0;
        u_host.xfer(SEL_SELF_GN, 24, 24'h00_0000, 1'b0, rd);
        `CHK(rd, coef[1])
        u_host.xfer(SEL_CTRL, 8, 24'h00_00FF, 1'b1, rd);
        `CHK(control_state, 8'hFE)
        // Ten control settings, each with a back-to-back burst of samples
        foreach (cfgs[c]) begin
            ctrl = cfgs[c];
            uni = (c == 6);
            u_host.xfer(SEL_CTRL, 8, {16'h0000, ctrl}, 1'b1, rd);
            unipolar_mode = uni;
            foreach (raws[k]) begin
                @(negedge clock);
                raw_valid = 1'b1;
                raw_data = raws[k];
                exq.push_back(model(raws[k]));
            end
            @(negedge clock);
            raw_valid = 1'b0;
            raw_data = ~raw_data;
            repeat (8) @(negedge clock);
        end
        `CHK(exq.size(), 0)
        stop_test();
    end
endmodule
bind ccc_calibration_correction_chain ccc_chain_checker u_chk (.clock,
    .rst_n, .acc_sel, .acc_start, .acc_shift, .acc_commit, .acc_sdo,
    .raw_valid, .raw_data, .unipolar_mode, .result_valid, .result_data,
    .control_state);
`default_nettype wire
